/* core/dio_pkg.sv */
/*
  package for the dual nibble digital io port: register offsets, field
  layout, reset values, bus answer codes and the bus carrier structs.
  assumes a 32-bit avalon-mm slave with word-aligned byte addresses.
*/
package dio_pkg;

  // register byte addresses (word aligned)
  localparam logic [3:0] drive_value_addr   = 4'h0;
  localparam logic [3:0] sample_value_addr  = 4'h4;
  localparam logic [3:0] port_enable_addr   = 4'h8;

  // field layout
  localparam int unsigned nibble_w   = 4;
  localparam int unsigned byte_w     = 8;
  localparam int unsigned port_cnt   = 2;
  localparam int unsigned data_w     = 32;

  // reset values
  localparam logic [7:0] drive_value_rst = 8'h00;
  localparam logic [1:0] port_enable_rst = 2'h0;

  // bus answer constants
  localparam logic [31:0] read_zero  = 32'h0000_0000;
  localparam logic [1:0]  resp_okay  = 2'h0;
  localparam logic [1:0]  resp_slverr = 2'h2;

  // avalon request bundle
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } av_req_t;

  // avalon answer bundle
  typedef struct packed {
    logic        waitrequest;
    logic        readdatavalid;
    logic [1:0]  response;
    logic [31:0] readdata;
  } av_rsp_t;

endpackage : dio_pkg

/* core/dio_nibble_port.sv */
/*
  one four-line port slice: output register selection and read-back mux.
  assumes the enable and value come from registers in the parent, and
  that the line input is synchronous to clk_in.
*/
`timescale 1ns/1ps
module dio_nibble_port
  import dio_pkg::*;
(
  // clock and reset
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  // control from register file
  input  wire logic                enable_in,
  input  wire logic [nibble_w-1:0] value_in,
  // connector lines
  input  wire logic [nibble_w-1:0] line_in,
  output logic      [nibble_w-1:0] line_out,
  output logic      [nibble_w-1:0] line_oe_out,
  // sampled state for the input register
  output logic      [nibble_w-1:0] sample_out
);

  logic [nibble_w-1:0] line_r, line_nxt;
  logic [nibble_w-1:0] oe_r, oe_nxt;
  logic [nibble_w-1:0] samp_r, samp_nxt;

  // drive and sample next values; lines float when the port is disabled
  always_comb begin
    line_nxt = value_in;
    oe_nxt   = {nibble_w{enable_in}};
    // read-back of an enabled port shows the driven value, not the pin, so a fight on the
    // wire never corrupts what software believes it wrote
    samp_nxt = enable_in ? value_in : line_in;
  end

  // registered outputs
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      line_r <= '0;
      oe_r   <= '0;
      samp_r <= '0;
    end else begin
      line_r <= line_nxt;
      oe_r   <= oe_nxt;
      samp_r <= samp_nxt;
    end
  end

  assign line_out    = line_r;
  assign line_oe_out = oe_r;
  assign sample_out  = samp_r;

endmodule : dio_nibble_port

/* core/dual_nibble_digital_io_port.sv */
/*
  dual nibble digital io port: eight lines as ports a and b with an
  avalon-mm register slave (fixed one wait cycle per access).
  assumes lines synchronous to clk_in and an external tristate resolver.
*/
`timescale 1ns/1ps
module dual_nibble_digital_io_port
  import dio_pkg::*;
(
  // clock and reset
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  // avalon-mm slave
  input  wire logic                avs_read_in,
  input  wire logic                avs_write_in,
  input  wire logic [3:0]          avs_address_in,
  input  wire logic [3:0]          avs_byteenable_in,
  input  wire logic [31:0]         avs_writedata_in,
  output logic                     avs_waitrequest_out,
  output logic [31:0]              avs_readdata_out,
  output logic [1:0]               avs_response_out,
  // port a lines
  input  wire logic [nibble_w-1:0] port_a_lines_in,
  output logic      [nibble_w-1:0] port_a_lines_out,
  output logic      [nibble_w-1:0] port_a_lines_oe_out,
  // port b lines
  input  wire logic [nibble_w-1:0] port_b_lines_in,
  output logic      [nibble_w-1:0] port_b_lines_out,
  output logic      [nibble_w-1:0] port_b_lines_oe_out
);

  // bus handshake states
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_ack  = 2'b10
  } bus_state_t;

  av_req_t    req;
  bus_state_t state_r, state_nxt;
  logic [7:0] drive_r, drive_nxt;
  logic [1:0] enable_r, enable_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] resp_r, resp_nxt;
  logic       wait_r, wait_nxt;
  logic [byte_w-1:0] sample_w;
  logic [nibble_w-1:0] line_in_w [port_cnt];
  logic [nibble_w-1:0] line_out_w [port_cnt];
  logic [nibble_w-1:0] line_oe_w [port_cnt];

  // address decode used by both read and write paths
  function automatic logic addr_mapped(input logic [3:0] a);
    return (a == drive_value_addr) || (a == sample_value_addr) ||
           (a == port_enable_addr);
  endfunction : addr_mapped

  assign req.read       = avs_read_in;
  assign req.write      = avs_write_in;
  assign req.address    = avs_address_in;
  assign req.byteenable = avs_byteenable_in;
  assign req.writedata  = avs_writedata_in;

  // register file and bus sequencer; the access is taken in st_ack, the
  // single edge where waitrequest is low, so a held request acts once
  always_comb begin
    state_nxt  = state_r;
    drive_nxt  = drive_r;
    enable_nxt = enable_r;
    rdata_nxt  = rdata_r;
    resp_nxt   = resp_r;
    wait_nxt   = 1'b1;
    unique case (state_r)
      st_idle: begin
        if (req.read || req.write) begin
          state_nxt = st_ack;
          wait_nxt  = 1'b0;
          resp_nxt  = addr_mapped(req.address) ? resp_okay : resp_slverr;
          rdata_nxt = read_zero;
          if (req.read) begin
            unique case (req.address)
              drive_value_addr:  rdata_nxt = {24'h00_0000, drive_r};
              sample_value_addr: rdata_nxt = {24'h00_0000, sample_w};
              port_enable_addr:  rdata_nxt = {30'h0000_0000, enable_r};
              default:           rdata_nxt = read_zero;
            endcase
          end
        end
      end
      st_ack: begin
        state_nxt = st_idle;
        if (req.write && req.byteenable[0]) begin
          if (req.address == drive_value_addr) begin
            drive_nxt = req.writedata[byte_w-1:0];
          end
          if (req.address == port_enable_addr) begin
            enable_nxt = req.writedata[port_cnt-1:0];
          end
        end
      end
    endcase
  end

  // registers only
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r  <= st_idle;
      drive_r  <= drive_value_rst;
      enable_r <= port_enable_rst;
      rdata_r  <= read_zero;
      resp_r   <= resp_okay;
      wait_r   <= 1'b1;
    end else begin
      state_r  <= state_nxt;
      drive_r  <= drive_nxt;
      enable_r <= enable_nxt;
      rdata_r  <= rdata_nxt;
      resp_r   <= resp_nxt;
      wait_r   <= wait_nxt;
    end
  end

  assign line_in_w[0] = port_a_lines_in;
  assign line_in_w[1] = port_b_lines_in;

  // one slice per port; port n takes output bits 4n+3..4n
  for (genvar p = 0; p < port_cnt; p++) begin : g_port
    dio_nibble_port u_port (
      .clk_in      (clk_in),
      .rst_in      (rst_in),
      .enable_in   (enable_r[p]),
      .value_in    (drive_r[p*nibble_w +: nibble_w]),
      .line_in     (line_in_w[p]),
      .line_out    (line_out_w[p]),
      .line_oe_out (line_oe_w[p]),
      .sample_out  (sample_w[p*nibble_w +: nibble_w])
    );
  end

  // outputs straight from slice and bus flip-flops
  assign port_a_lines_out    = line_out_w[0];
  assign port_a_lines_oe_out = line_oe_w[0];
  assign port_b_lines_out    = line_out_w[1];
  assign port_b_lines_oe_out = line_oe_w[1];
  assign avs_waitrequest_out = wait_r;
  assign avs_readdata_out    = rdata_r;
  assign avs_response_out    = resp_r;

endmodule : dual_nibble_digital_io_port

/* tb/dio_port_asserts.sv */
/* bus and line checks for the dual nibble port.
   assumes one clock and binding into the top module. */
`timescale 1ns/1ps
module dio_port_chk
  import dio_pkg::*;
(
  input wire logic        clk_in, rst_in, avs_read_in, avs_write_in,
  input wire logic        avs_waitrequest_out,
  input wire logic [3:0]  avs_address_in, avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in, avs_readdata_out,
  input wire logic [1:0]  avs_response_out,
  input wire logic [3:0]  port_a_lines_in, port_a_lines_out,
  input wire logic [3:0]  port_a_lines_oe_out, port_b_lines_in,
  input wire logic [3:0]  port_b_lines_out, port_b_lines_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // accepted writes; byte lane 0 must be enabled to count
  wire wr_ok = !avs_waitrequest_out && avs_write_in && avs_byteenable_in[0];
  wire wr0 = wr_ok && avs_address_in == drive_value_addr;
  wire wr8 = wr_ok && avs_address_in == port_enable_addr;
  chk_wait_once: assert property ($fell(avs_waitrequest_out) |=>
    avs_waitrequest_out) else $error("wait low too long");
  chk_wait_answer: assert property ((avs_read_in || avs_write_in) &&
    avs_waitrequest_out |=> !avs_waitrequest_out) else $error("no answer");
  chk_drive_byte: assert property (wr0 |-> ##2
    {port_b_lines_out, port_a_lines_out} == $past(avs_writedata_in[7:0], 2))
    else $error("drive value");
  chk_oe_whole: assert property (port_a_lines_oe_out inside {4'h0, 4'hf})
    else $error("oe split");
  chk_oe_a_follow: assert property (wr8 |-> ##2
    port_a_lines_oe_out == {4{$past(avs_writedata_in[0], 2)}})
    else $error("oe a");
  chk_oe_b_follow: assert property (wr8 |-> ##2
    port_b_lines_oe_out == {4{$past(avs_writedata_in[1], 2)}})
    else $error("oe b");
  chk_reset_clear: assert property ($fell(rst_in) |->
    {port_a_lines_oe_out, port_b_lines_oe_out, port_a_lines_out,
    port_b_lines_out} == 16'h0000) else $error("reset state");
  chk_upper_zero: assert property (!avs_waitrequest_out && avs_read_in |->
    avs_readdata_out[31:8] == 24'h00_0000) else $error("upper bits");
  cover property (wr0);
  cover property (wr8);
  cover property (!avs_waitrequest_out && avs_address_in == 4'h4);
endmodule : dio_port_chk
bind dual_nibble_digital_io_port dio_port_chk i_chk (.*);

/* tb/dio_ext_dev.sv */
/* outside device on the connector lines.
   assumes per-line output enables from the port. */
`timescale 1ns/1ps
module dio_ext_dev (
  // port side and outside levels
  input  wire logic [3:0] drv_a_in, oe_a_in, drv_b_in, oe_b_in,
  input  wire logic [3:0] lvl_a_in, lvl_b_in,
  // resolved wire levels
  output logic      [3:0] wire_a_out, wire_b_out
);
  // a released line carries the outside level, never the stale drive
  assign wire_a_out = (oe_a_in & drv_a_in) | (~oe_a_in & lvl_a_in);
  assign wire_b_out = (oe_b_in & drv_b_in) | (~oe_b_in & lvl_b_in);
endmodule : dio_ext_dev

/* tb/dual_nibble_digital_io_port_tb_top.sv */
/* self-checking bench: avalon accesses and line levels.
   assumes the outside device model resolves the lines. */
`timescale 1ns/1ps
module dual_nibble_digital_io_port_tb_top;
  import dio_pkg::*;
  logic        clk_in = 0, rst_in = 1, avs_read_in = 0, avs_write_in = 0;
  logic        avs_waitrequest_out;
  logic [3:0]  avs_address_in = 4'h0, avs_byteenable_in = 4'hf;
  logic [3:0]  port_a_lines_in, port_a_lines_out, port_a_lines_oe_out;
  logic [3:0]  port_b_lines_in, port_b_lines_out, port_b_lines_oe_out;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
  logic [1:0]  avs_response_out;
  int          n_mismatch = 0, cmp_count = 0;
  initial forever #25 clk_in = ~clk_in;
  dual_nibble_digital_io_port i_dut (.*);
  dio_ext_dev i_ext (.drv_a_in(port_a_lines_out), .oe_a_in(port_a_lines_oe_out),
    .drv_b_in(port_b_lines_out), .oe_b_in(port_b_lines_oe_out),
    .lvl_a_in(4'h5), .lvl_b_in(4'ha), .wire_a_out(port_a_lines_in),
    .wire_b_out(port_b_lines_in));
  task automatic chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // one access, held until waitrequest is seen low; reads compare with d
  task automatic acc(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n = 0;
    logic [31:0] rd;
    repeat (3) @(posedge clk_in);
    avs_read_in <= !w;
    avs_write_in <= w;
    avs_address_in <= a;
    avs_writedata_in <= d;
    // look mid-cycle so the bus flops have settled; the next rising edge
    // is then the accepting one
    do begin
      @(negedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      report_and_stop();
    end
    rd = avs_readdata_out;
    @(posedge clk_in);
    if (!w) chk("readdata", rd, d);
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : acc
  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // watchdog, far beyond the roughly 100 cycles the tests need
  initial begin
    #1ms;
    n_mismatch++;
    report_and_stop();
  end
  // main sequence: reset, released ports, each port driven, refusals
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    acc(0, 4'h0, 32'h0);
    acc(0, 4'h8, 32'h0);
    acc(0, 4'h4, 32'ha5);
    acc(1, 4'h0, 32'h3c);
    acc(1, 4'h8, 32'h1);
    acc(0, 4'h4, 32'hac);
    chk("lines a", {port_b_lines_oe_out, port_a_lines_in}, 32'hc);
    acc(1, 4'h8, 32'h2);
    acc(0, 4'h4, 32'h35);
    chk("lines b", {port_a_lines_oe_out, port_b_lines_in}, 32'h3);
    acc(1, 4'h8, 32'h3);
    acc(1, 4'h0, 32'h96);
    acc(0, 4'h4, 32'h96);
    avs_byteenable_in <= 4'h0;
    acc(1, 4'h0, 32'hff);
    avs_byteenable_in <= 4'hf;
    acc(0, 4'h0, 32'h96);
    acc(0, 4'hc, 32'h0);
    chk("response", avs_response_out, resp_slverr);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    acc(0, 4'h8, 32'h0);
    acc(0, 4'h4, 32'ha5);
    report_and_stop();
  end
endmodule : dual_nibble_digital_io_port_tb_top
